// ===== ssfid_top.sv
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "ssfid_defs.svh"
module ssfid_top #(
    parameter int FIFO_DEPTH = 8,
    localparam int AW = $clog2(FIFO_DEPTH)
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] bus_addr_i,
    input wire logic [31:0] bus_wdata_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    output logic [31:0] bus_rdata_o,
    output logic irq_o,
    output logic rx_dma_req_o,
    output logic tx_dma_req_o,
    input wire logic link_clk_i,
    input wire logic link_sel_n_i,
    input wire logic link_din_i,
    output logic link_dout_o,
    output logic link_dout_oe_o
);
    localparam logic [9:0] RXTO_CYC = 10'(`SSFID_RXTO_CYC);

    // Configuration and interrupt state
    logic enable, next_enable;
    logic [3:0] wm1, next_wm1;
    logic [3:0] imask, next_imask;
    logic rxto, next_rxto;
    logic rxor, next_rxor;
    logic rx_dma_en, next_rx_dma_en;
    logic tx_dma_en, next_tx_dma_en;
    logic rd_sel_data, next_rd_sel_data;
    logic [31:0] rdata, next_rdata;
    logic [9:0] to_cnt, next_to_cnt;
    logic to_set;

    // Link state
    logic clk_s1, clk_s2, clk_s3;
    logic sel_s1, sel_s2;
    logic din_s1, din_s2;
    ssfid_pkg::ssfid_link_state_t state, next_state;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [15:0] rx_shift, next_rx_shift;
    logic [15:0] tx_shift, next_tx_shift;
    logic [15:0] tx_hold, next_tx_hold;
    logic hold_valid, next_hold_valid;
    logic hold_pend, next_hold_pend;
    logic tx_loaded, next_tx_loaded;
    logic dout, next_dout;
    logic dout_oe, next_dout_oe;

    logic [15:0] data_mask;
    logic [15:0] rx_word;
    logic link_rise, link_fall, link_act;
    logic tx_push, tx_pop, rx_push, rx_pop;
    logic [15:0] tx_q, rx_q;
    logic tx_full, tx_empty, rx_full, rx_empty;
    logic [AW:0] tx_level, rx_level;
    logic busy;
    logic [3:0] ris, mis;
    logic wr_ris, wr_dmaclr;

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_mask
            assign data_mask[gi] = (4'(gi) <= wm1);
        end
    endgenerate

    ssfid_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_en_i(tx_push),
        .wr_data_i(bus_wdata_i[15:0] & data_mask),
        .rd_en_i(tx_pop),
        .rd_data_o(tx_q),
        .full_o(tx_full),
        .empty_o(tx_empty),
        .level_o(tx_level)
    );

    ssfid_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_en_i(rx_push),
        .wr_data_i(rx_word),
        .rd_en_i(rx_pop),
        .rd_data_o(rx_q),
        .full_o(rx_full),
        .empty_o(rx_empty),
        .level_o(rx_level)
    );

    assign tx_push = bus_wr_i && (bus_addr_i == `SSFID_OFS_DATA);
    assign rx_pop = bus_rd_i && (bus_addr_i == `SSFID_OFS_DATA);
    assign wr_ris = bus_wr_i && (bus_addr_i == `SSFID_OFS_RIS);
    assign wr_dmaclr = bus_wr_i && (bus_addr_i == `SSFID_OFS_DMACLR);

    // Only the second and third stages feed logic
    assign link_rise = clk_s2 && !clk_s3;
    assign link_fall = !clk_s2 && clk_s3;
    assign link_act = enable && !sel_s2;
    assign rx_word = {rx_shift[14:0], din_s2} & data_mask;

    assign busy = !tx_empty || hold_valid || hold_pend || tx_loaded;
    assign ris = {rxor, rxto, (rx_level >= (AW+1)'(FIFO_DEPTH / 2)),
                  (tx_level <= (AW+1)'(FIFO_DEPTH / 2))};
    assign mis = ris & imask;
    assign irq_o = |mis;
    assign rx_dma_req_o = rx_dma_en && !rx_empty;
    assign tx_dma_req_o = tx_dma_en && !tx_full;
    assign link_dout_o = dout;
    assign link_dout_oe_o = dout_oe;
    assign bus_rdata_o = rd_sel_data ? {16'h0000, rx_q & data_mask} : rdata;

    // Link shifter: bits sampled on the rising edge, driven on the falling edge
    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_rx_shift = rx_shift;
        next_tx_shift = tx_shift;
        next_tx_hold = tx_hold;
        next_hold_valid = hold_valid;
        next_hold_pend = hold_pend;
        next_tx_loaded = tx_loaded;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        // One word is staged ahead so a frame can start without waiting on the queue
        if (hold_pend) begin
            next_tx_hold = tx_q;
            next_hold_valid = 1'b1;
            next_hold_pend = 1'b0;
        end else if (!hold_valid && !tx_empty) begin
            tx_pop = 1'b1;
            next_hold_pend = 1'b1;
        end
        case (state)
            ssfid_pkg::link_idle: begin
                if (link_act) begin
                    next_state = ssfid_pkg::link_frame;
                    next_bit_cnt = 4'h0;
                    // A word loaded as the last frame closed is still owed to the far side
                    if (!tx_loaded) begin
                        next_tx_shift = hold_valid ? tx_hold : 16'h0000;
                        next_tx_loaded = hold_valid;
                        if (hold_valid) begin
                            next_hold_valid = 1'b0;
                        end
                    end
                end
            end
            ssfid_pkg::link_frame: begin
                if (!link_act) begin
                    // A partial word is dropped when the select or the enable goes away;
                    // a loaded word with no bit sampled yet waits for the next frame
                    next_state = ssfid_pkg::link_idle;
                    next_bit_cnt = 4'h0;
                    next_tx_loaded = tx_loaded && (bit_cnt == 4'h0);
                end else if (link_rise) begin
                    next_rx_shift = {rx_shift[14:0], din_s2};
                    if (bit_cnt == wm1) begin
                        rx_push = 1'b1;
                        next_bit_cnt = 4'h0;
                        next_tx_shift = hold_valid ? tx_hold : 16'h0000;
                        next_tx_loaded = hold_valid;
                        if (hold_valid) begin
                            next_hold_valid = 1'b0;
                        end
                    end else begin
                        next_bit_cnt = bit_cnt + 4'h1;
                    end
                end else if (link_fall && (bit_cnt != 4'h0)) begin
                    next_tx_shift = {tx_shift[14:0], 1'b0};
                end
            end
            default: begin
                next_state = ssfid_pkg::link_idle;
            end
        endcase
        next_dout = next_tx_shift[wm1];
        next_dout_oe = (next_state == ssfid_pkg::link_frame);
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            clk_s1 <= 1'b0;
            clk_s2 <= 1'b0;
            clk_s3 <= 1'b0;
            sel_s1 <= 1'b1;
            sel_s2 <= 1'b1;
            din_s1 <= 1'b0;
            din_s2 <= 1'b0;
            state <= ssfid_pkg::link_idle;
            bit_cnt <= 4'h0;
            rx_shift <= 16'h0000;
            tx_shift <= 16'h0000;
            tx_hold <= 16'h0000;
            hold_valid <= 1'b0;
            hold_pend <= 1'b0;
            tx_loaded <= 1'b0;
            dout <= 1'b0;
            dout_oe <= 1'b0;
        end else begin
            clk_s1 <= link_clk_i;
            clk_s2 <= clk_s1;
            clk_s3 <= clk_s2;
            sel_s1 <= link_sel_n_i;
            sel_s2 <= sel_s1;
            din_s1 <= link_din_i;
            din_s2 <= din_s1;
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            rx_shift <= next_rx_shift;
            tx_shift <= next_tx_shift;
            tx_hold <= next_tx_hold;
            hold_valid <= next_hold_valid;
            hold_pend <= next_hold_pend;
            tx_loaded <= next_tx_loaded;
            dout <= next_dout;
            dout_oe <= next_dout_oe;
        end
    end

    // Registers, interrupt flags and read data
    always_comb begin
        next_enable = enable;
        next_wm1 = wm1;
        next_imask = imask;
        next_rx_dma_en = rx_dma_en;
        next_tx_dma_en = tx_dma_en;
        next_rd_sel_data = rx_pop;
        next_rdata = 32'h0000_0000;
        // Timeout counts quiet cycles while unread words wait
        next_to_cnt = to_cnt;
        to_set = 1'b0;
        if (rx_empty || rx_pop || link_rise || link_fall) begin
            next_to_cnt = 10'h000;
        end else if (to_cnt != RXTO_CYC) begin
            next_to_cnt = to_cnt + 10'h001;
            to_set = (to_cnt == RXTO_CYC - 10'h001);
        end
        // A new event wins over a clear in the same cycle
        next_rxto = to_set || (rxto && !(wr_ris && bus_wdata_i[`SSFID_IRQ_RXTO]));
        next_rxor = (rx_push && rx_full) ||
                    (rxor && !(wr_ris && bus_wdata_i[`SSFID_IRQ_RXOR]));
        if (bus_wr_i) begin
            case (bus_addr_i)
                `SSFID_OFS_CTRL: begin
                    next_enable = bus_wdata_i[`SSFID_CTRL_EN];
                    // Widths under four bits are raised to the smallest legal frame
                    next_wm1 = (bus_wdata_i[`SSFID_CTRL_W_MSB:`SSFID_CTRL_W_LSB] <
                                `SSFID_WM1_MIN) ? `SSFID_WM1_MIN :
                               bus_wdata_i[`SSFID_CTRL_W_MSB:`SSFID_CTRL_W_LSB];
                end
                `SSFID_OFS_IMASK: next_imask = bus_wdata_i[3:0];
                `SSFID_OFS_DMASET: begin
                    next_rx_dma_en = rx_dma_en || bus_wdata_i[`SSFID_DMA_RX];
                    next_tx_dma_en = tx_dma_en || bus_wdata_i[`SSFID_DMA_TX];
                end
                `SSFID_OFS_DMACLR: begin
                    next_rx_dma_en = rx_dma_en && !bus_wdata_i[`SSFID_DMA_RX];
                    next_tx_dma_en = tx_dma_en && !bus_wdata_i[`SSFID_DMA_TX];
                end
                default: begin
                end
            endcase
        end
        if (bus_rd_i) begin
            case (bus_addr_i)
                `SSFID_OFS_STAT: next_rdata = {27'h0, rx_full, tx_empty, busy,
                                               !rx_empty, !tx_full};
                `SSFID_OFS_CTRL: next_rdata = {24'h0, wm1, 3'h0, enable};
                `SSFID_OFS_IMASK: next_rdata = {28'h0, imask};
                `SSFID_OFS_RIS: next_rdata = {28'h0, ris};
                `SSFID_OFS_MIS: next_rdata = {28'h0, mis};
                `SSFID_OFS_DMASET, `SSFID_OFS_DMACLR: next_rdata = {30'h0, tx_dma_en, rx_dma_en};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            enable <= 1'b0;
            wm1 <= `SSFID_WM1_RST;
            imask <= 4'h0;
            rxto <= 1'b0;
            rxor <= 1'b0;
            rx_dma_en <= 1'b0;
            tx_dma_en <= 1'b0;
            rd_sel_data <= 1'b0;
            rdata <= 32'h0000_0000;
            to_cnt <= 10'h000;
        end else begin
            enable <= next_enable;
            wm1 <= next_wm1;
            imask <= next_imask;
            rxto <= next_rxto;
            rxor <= next_rxor;
            rx_dma_en <= next_rx_dma_en;
            tx_dma_en <= next_tx_dma_en;
            rd_sel_data <= next_rd_sel_data;
            rdata <= next_rdata;
            to_cnt <= next_to_cnt;
        end
    end

    property p_tx_trunc;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        tx_push && tx_empty && !hold_valid && !hold_pend
        |=> (tx_level == 1) ##1 ((tx_q & ~$past(data_mask, 2)) == 16'h0000);
    endproperty
    a_tx_trunc: assert property (p_tx_trunc) else $error("tx write not queued");

    property p_rx_width;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        rx_pop |=> (bus_rdata_o[31:16] == 16'h0000) && ((bus_rdata_o[15:0] & ~data_mask) == 16'h0000);
    endproperty
    a_rx_width: assert property (p_rx_width) else $error("rx data beyond frame width");

    property p_width_min;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        bus_wr_i && (bus_addr_i == `SSFID_OFS_CTRL) |=> (wm1 >= `SSFID_WM1_MIN) && data_mask[3];
    endproperty
    a_width_min: assert property (p_width_min) else $error("frame width below four");

    property p_dma_clr;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        wr_dmaclr && bus_wdata_i[`SSFID_DMA_RX] && !bus_wdata_i[`SSFID_DMA_TX]
        |=> !rx_dma_en && (tx_dma_en == $past(tx_dma_en));
    endproperty
    a_dma_clr: assert property (p_dma_clr) else $error("dma clear touched other side");

    property p_ovr_set;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        rx_push && rx_full |=> rxor ##1 (rxor || $past(wr_ris));
    endproperty
    a_ovr_set: assert property (p_ovr_set) else $error("overrun not latched");

    property p_to_sticky;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        rxto && !wr_ris |=> rxto;
    endproperty
    a_to_sticky: assert property (p_to_sticky) else $error("timeout dropped without clear");

    property p_irq_or;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (imask[`SSFID_IRQ_RXOR] && rxor) || (imask[`SSFID_IRQ_RXTO] && rxto) |-> irq_o;
    endproperty
    a_irq_or: assert property (p_irq_or) else $error("unmasked source without interrupt");

    property p_busy;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        tx_push && !tx_full |=> busy [*3];
    endproperty
    a_busy: assert property (p_busy) else $error("busy low with queued word");

    property p_disable_stops;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        !enable |=> !link_dout_oe_o;
    endproperty
    a_disable_stops: assert property (p_disable_stops) else $error("link driven while disabled");
endmodule : ssfid_top

// ===== ssfid_defs.svh
// Overview of operation
// - A word written to the data register enters the transmit queue with only its low N bits.
// - A word read from the data register carries the received frame in its low N bits.
// - The frame width N may be set to any value from 4 to 16 bits.
// - A receive-queue-not-empty flag is readable at any time.
// - A transmit-queue-not-full flag is readable at any time.
// - Receive and transmit DMA requests have separate enables.
// - Disabling DMA for one direction leaves the other direction's enable untouched.
// - Four interrupt sources, each with a mask bit: tx service, rx service, timeout, overrun.
// - Timeout and overrun are sticky until software clears either or both.
// - Raw status and masked status of the four sources are both readable.
// - Busy holds until the transmit queue is empty and the last word has left the shifter.
`ifndef SSFID_DEFS_SVH
`define SSFID_DEFS_SVH

`define SSFID_OFS_DATA 8'h00
`define SSFID_OFS_STAT 8'h04
`define SSFID_OFS_CTRL 8'h08
`define SSFID_OFS_IMASK 8'h0C
`define SSFID_OFS_RIS 8'h10
`define SSFID_OFS_MIS 8'h14
`define SSFID_OFS_DMASET 8'h18
`define SSFID_OFS_DMACLR 8'h1C

`define SSFID_IRQ_TXFF 0
`define SSFID_IRQ_RXFF 1
`define SSFID_IRQ_RXTO 2
`define SSFID_IRQ_RXOR 3

`define SSFID_CTRL_EN 0
`define SSFID_CTRL_W_LSB 4
`define SSFID_CTRL_W_MSB 7

`define SSFID_DMA_RX 0
`define SSFID_DMA_TX 1

`define SSFID_WM1_RST 4'h7
`define SSFID_WM1_MIN 4'h3

`define SSFID_CLK_PS 4000
`define SSFID_RXTO_NS 2560
`define SSFID_RXTO_CYC ((`SSFID_RXTO_NS * 1000 + `SSFID_CLK_PS - 1) / `SSFID_CLK_PS)

`endif

// ===== ssfid_pkg.sv
package ssfid_pkg;
    typedef enum logic {
        link_idle,
        link_frame
    } ssfid_link_state_t;
endpackage : ssfid_pkg

// ===== ssfid_fifo.sv
`timescale 1ns/1ps
module ssfid_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8,
    localparam int AW = $clog2(DEPTH)
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic wr_en_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    input wire logic rd_en_i,
    output logic [WIDTH-1:0] rd_data_o,
    output logic full_o,
    output logic empty_o,
    output logic [AW:0] level_o
);
    // DEPTH must be a power of two: pointers wrap with one extra lap bit
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    logic [AW:0] next_wptr;
    logic [AW:0] next_rptr;
    logic [WIDTH-1:0] rd_data;
    logic [WIDTH-1:0] next_rd_data;
    logic wr_ok;
    logic rd_ok;

    assign level_o = wptr - rptr;
    assign full_o = (level_o == (AW+1)'(DEPTH));
    assign empty_o = (wptr == rptr);
    assign wr_ok = wr_en_i && !full_o;
    assign rd_ok = rd_en_i && !empty_o;
    assign rd_data_o = rd_data;

    always_comb begin
        next_wptr = wptr + {{AW{1'b0}}, wr_ok};
        next_rptr = rptr + {{AW{1'b0}}, rd_ok};
        next_rd_data = rd_ok ? mem[rptr[AW-1:0]] : '0;
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            wptr <= '0;
            rptr <= '0;
            rd_data <= '0;
        end else begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            rd_data <= next_rd_data;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (wr_ok) begin
            mem[wptr[AW-1:0]] <= wr_data_i;
        end
    end
endmodule : ssfid_fifo

// ===== ssfid_link_master.sv
`timescale 1ns/1ps
module ssfid_link_master (
    output logic link_clk_o,
    output logic link_sel_n_o,
    output logic link_din_o,
    input wire logic link_dout_i,
    input wire logic link_dout_oe_i
);
    logic line_last = 1'b0;
    logic oe_seen = 1'b0;

    // Clock idles low and stands still between frames
    initial begin
        link_clk_o = 1'b0;
        link_sel_n_o = 1'b1;
        link_din_o = 1'b0;
    end

    task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        oe_seen = 1'b0;
        link_sel_n_o = 1'b0;
        #40;
        for (int i = n - 1; i >= 0; i--) begin
            link_din_o = tx[i]; // Bits go out MSB first
            #40;
            link_clk_o = 1'b1;
            // An undriven line reads back as the inverse of its last level
            line_last = link_dout_oe_i ? link_dout_i : ~line_last;
            oe_seen = oe_seen | link_dout_oe_i;
            rx = {rx[14:0], line_last};
            #40;
            link_clk_o = 1'b0;
        end
        #40;
        link_sel_n_o = 1'b1;
        link_din_o = ~link_din_o;
        #40;
    endtask : xfer
endmodule : ssfid_link_master

// ===== test_sync_serial_fifo_irq_dma.sv
`timescale 1ns/1ps
`include "ssfid_defs.svh"
module test_sync_serial_fifo_irq_dma;
    localparam int DEPTH = 8;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] bus_addr_i = 8'h00;
    logic [31:0] bus_wdata_i = 32'h0;
    logic bus_wr_i = 1'b0;
    logic bus_rd_i = 1'b0;
    logic [31:0] bus_rdata_o;
    logic irq_o, rx_dma_req_o, tx_dma_req_o;
    logic link_clk_i, link_sel_n_i, link_din_i, link_dout_o, link_dout_oe_o;
    int err_count = 0;
    int tests_run = 0;
    int seed = 19650;
    int n, cnt;
    logic [31:0] d, twr, e;
    logic [15:0] rxw, got;
    logic [31:0] tx_q[$];
    logic [31:0] sent_q[$];

    ssfid_top #(.FIFO_DEPTH(DEPTH)) ssfid_top_inst (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .bus_addr_i(bus_addr_i),
        .bus_wdata_i(bus_wdata_i),
        .bus_wr_i(bus_wr_i),
        .bus_rd_i(bus_rd_i),
        .bus_rdata_o(bus_rdata_o),
        .irq_o(irq_o),
        .rx_dma_req_o(rx_dma_req_o),
        .tx_dma_req_o(tx_dma_req_o),
        .link_clk_i(link_clk_i),
        .link_sel_n_i(link_sel_n_i),
        .link_din_i(link_din_i),
        .link_dout_o(link_dout_o),
        .link_dout_oe_o(link_dout_oe_o)
    );

    ssfid_link_master ssfid_link_master_inst (
        .link_clk_o(link_clk_i),
        .link_sel_n_o(link_sel_n_i),
        .link_din_o(link_din_i),
        .link_dout_i(link_dout_o),
        .link_dout_oe_i(link_dout_oe_o)
    );

    initial begin
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    function automatic logic [31:0] lowbits(input logic [31:0] v, input int w);
        return v & ((32'h1 << w) - 32'h1);
    endfunction : lowbits

    // A gap cycle after each strobe keeps the driver to one assignment per step
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk_i);
        bus_addr_i <= a;
        bus_wdata_i <= v;
        bus_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        bus_wr_i <= 1'b0;
        // Let the write settle before any output is looked at
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk_i);
        bus_addr_i <= a;
        bus_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        bus_rd_i <= 1'b0;
        #1;
        v = bus_rdata_o;
    endtask : rd

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        tests_run++;
        if (g !== x) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
            err_count++;
        end
    endtask : chk

    task automatic rchk(input logic [7:0] a, input logic [31:0] x);
        rd(a, d);
        chk(d, x);
    endtask : rchk

    task automatic xfer(input logic [15:0] w, input int bits);
        ssfid_link_master_inst.xfer(w, bits, got);
    endtask : xfer

    task automatic done(input string s);
        $display("test %s done", s);
    endtask : done

    task automatic summarize;
        $display("counts: tests_run=%0d err_count=%0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    initial begin
        #200000;
        err_count++;
        summarize();
    end

    initial begin
        repeat (2) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        rchk(`SSFID_OFS_STAT, 32'h09);
        rchk(`SSFID_OFS_RIS, 32'h1);
        rchk(`SSFID_OFS_MIS, 32'h0);
        rchk(`SSFID_OFS_CTRL, 32'h70);
        rchk(8'h20, 32'h0);
        wr(`SSFID_OFS_IMASK, 32'h1);
        chk({31'h0, irq_o}, 32'h1);
        wr(`SSFID_OFS_IMASK, 32'h0);
        wr(`SSFID_OFS_CTRL, 32'h00);
        rchk(`SSFID_OFS_CTRL, 32'h30);
        done("reset");
        // Both width limits first, then random widths
        for (int i = 0; i < 12; i++) begin
            n = (i < 2) ? 4 + 12 * i : 4 + ($unsigned($random(seed)) % 13);
            wr(`SSFID_OFS_CTRL, (n - 1) << 4);
            wr(`SSFID_OFS_CTRL, ((n - 1) << 4) | 1);
            twr = $random(seed);
            e = lowbits($random(seed), n);
            rxw = e[15:0];
            wr(`SSFID_OFS_DATA, twr);
            rd(`SSFID_OFS_STAT, d);
            chk({31'h0, d[2]}, 32'h1);
            xfer(rxw, n);
            chk({16'h0, got}, lowbits(twr, n));
            rd(`SSFID_OFS_STAT, d);
            chk({30'h0, d[2:1]}, 32'h1);
            rchk(`SSFID_OFS_DATA, e);
        end
        done("widths");
        wr(`SSFID_OFS_CTRL, 32'h71);
        cnt = 0;
        d = 32'h1;
        while (d[0] === 1'b1 && cnt < DEPTH + 2) begin
            twr = $random(seed);
            tx_q.push_back(lowbits(twr, 8));
            wr(`SSFID_OFS_DATA, twr);
            cnt++;
            rd(`SSFID_OFS_STAT, d);
        end
        chk({31'h0, d[0]}, 32'h0);
        chk(32'(cnt == DEPTH || cnt == DEPTH + 1), 32'h1);
        wr(`SSFID_OFS_DATA, 32'hA5);
        wr(`SSFID_OFS_DMASET, 32'h2);
        chk({31'h0, tx_dma_req_o}, 32'h0);
        for (int i = 0; i <= DEPTH; i++) begin
            e = lowbits($random(seed), 8);
            sent_q.push_back(e);
            xfer(e[15:0], 8);
            twr = (tx_q.size() > 0) ? tx_q.pop_front() : 32'h0;
            chk({16'h0, got}, twr);
        end
        rchk(`SSFID_OFS_RIS, 32'hB);
        chk({31'h0, irq_o}, 32'h0);
        wr(`SSFID_OFS_IMASK, 32'h8);
        chk({31'h0, irq_o}, 32'h1);
        rchk(`SSFID_OFS_MIS, 32'h8);
        wr(`SSFID_OFS_RIS, 32'h8);
        rchk(`SSFID_OFS_RIS, 32'h3);
        chk({31'h0, irq_o}, 32'h0);
        rd(`SSFID_OFS_STAT, d);
        chk({27'h0, d[4], 3'h0, d[0]}, 32'h11);
        wr(`SSFID_OFS_DMASET, 32'h1);
        chk({30'h0, rx_dma_req_o, tx_dma_req_o}, 32'h3);
        wr(`SSFID_OFS_DMACLR, 32'h2);
        rchk(`SSFID_OFS_DMASET, 32'h1);
        chk({30'h0, rx_dma_req_o, tx_dma_req_o}, 32'h2);
        for (int i = 0; i < DEPTH; i++) begin
            rchk(`SSFID_OFS_DATA, sent_q.pop_front());
        end
        rchk(`SSFID_OFS_DATA, 32'h0);
        chk({31'h0, rx_dma_req_o}, 32'h0);
        wr(`SSFID_OFS_DMACLR, 32'h1);
        rchk(`SSFID_OFS_DMASET, 32'h0);
        done("fill_overrun_dma");
        e = lowbits($random(seed), 8);
        xfer(e[15:0], 8);
        // The wait spans follow the fixed 640-cycle idle limit
        repeat (580) @(posedge sys_clk_i);
        rd(`SSFID_OFS_RIS, d);
        chk({31'h0, d[2]}, 32'h0);
        repeat (80) @(posedge sys_clk_i);
        rd(`SSFID_OFS_RIS, d);
        chk({31'h0, d[2]}, 32'h1);
        wr(`SSFID_OFS_IMASK, 32'h4);
        chk({31'h0, irq_o}, 32'h1);
        wr(`SSFID_OFS_RIS, 32'h4);
        chk({31'h0, irq_o}, 32'h0);
        rchk(`SSFID_OFS_DATA, e);
        done("timeout");
        wr(`SSFID_OFS_CTRL, 32'h70);
        xfer(16'h5A, 8);
        chk({31'h0, ssfid_link_master_inst.oe_seen}, 32'h0);
        rd(`SSFID_OFS_STAT, d);
        chk({31'h0, d[1]}, 32'h0);
        done("disable");
        summarize();
    end
endmodule : test_sync_serial_fifo_irq_dma
